// ---- logic/cmc_pkg.sv ----
// Constants for the CAN mode and configuration control block
// Contract
// - Sleep waits for idle bus, empty transmit
// - sleep_ack set once sleep is entered
// - sleep_request cannot set while wake flag pending
// - Sleep ends by software clear or wake
// - Request clears ignored before their acknowledge
// - init_request aborts traffic, drops synchronisation
// - init_ack marks init; both bits one
// - Init returns listed registers to reset
// - Config registers writable only in init
// - Resync: 11 recessive, or 128 when bus-off
// - tx_pin recessive at once on init request
// - tx_pin recessive in stop, wait+stop_in_wait
// - frame_received_flag set only in normal mode
// - module_enable write-once, special modes repeatable
// - clock_select picks oscillator or bus clock
// - loopback_select feeds transmitter into receiver
// - monitor_only receives, never transmits, freezes counters
// - busoff_recovery_mode: automatic or software recovery
// - wake_filter_select needs wake_pulse_min dominant pulse
// - tx_pin low dominant, high recessive
// - Clearing sleep_request or waking clears sleep_ack
// - wake_enable zero ignores bus; set before sleep
package cmc_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_CTL_A = 6'h00;
	localparam logic [5:0] OFF_CTL_B = 6'h01;
	localparam logic [5:0] OFF_TIMING_A = 6'h02;
	localparam logic [5:0] OFF_TIMING_B = 6'h03;
	localparam logic [5:0] OFF_RX_FLAGS = 6'h04;
	localparam logic [5:0] OFF_RX_IEN = 6'h05;
	localparam logic [5:0] OFF_TX_FLAGS = 6'h06;
	localparam logic [5:0] OFF_TX_IEN = 6'h07;
	localparam logic [5:0] OFF_ABORT_REQ = 6'h08;
	localparam logic [5:0] OFF_ABORT_ACK = 6'h09;
	localparam logic [5:0] OFF_BUF_SEL = 6'h0A;
	localparam logic [5:0] OFF_ACC_CTL = 6'h0B;
	localparam logic [5:0] OFF_ACC_BASE = 6'h10;
	// control_reg_a fields
	localparam int A_FRAME = 7;
	localparam int A_RXACT = 6;
	localparam int A_STOPWAIT = 5;
	localparam int A_SYNC = 4;
	localparam int A_TIMER = 3;
	localparam int A_WAKE_EN = 2;
	localparam int A_SLEEP_RQ = 1;
	localparam int A_INIT_RQ = 0;
	// control_reg_b fields
	localparam int B_ENABLE = 7;
	localparam int B_CLKSEL = 6;
	localparam int B_LOOPBACK = 5;
	localparam int B_MONITOR = 4;
	localparam int B_BUSOFF_RECOVERY_MODE = 3;
	localparam int B_WAKE_FILT = 2;
	localparam int B_SLEEP_ACK = 1;
	localparam int B_INIT_ACK = 0;
	localparam int RX_WAKE_FLAG = 7;
	localparam logic [7:0] CTL_A_RST = 8'h00;
	localparam logic [7:0] CTL_B_RST = 8'h00;
	localparam logic [7:0] GEN_RST = 8'h00;
	localparam logic [7:0] TX_FLAGS_RST = 8'h07;
	// Resynchronisation counts
	localparam int RECESSIVE_RUN = 11;
	localparam int BUSOFF_RUNS = 128;
	// Wake filter timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_PULSE_MIN_NS = 2000;
	localparam int WAKE_CYCLES =
		(WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_INIT = 4'b0100,
		ST_RESYNC = 4'b1000
	} cmc_state_t;
endpackage : cmc_pkg

// ---- logic/cmc_sync.sv ----
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module cmc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1_reg <= RST_VAL;
			stage2_reg <= RST_VAL;
		end else begin
			stage1_reg <= i_async;
			stage2_reg <= stage1_reg;
		end
	end

	assign o_sync = stage2_reg;
endmodule : cmc_sync
`default_nettype wire

// ---- logic/cmc_accept_mem.sv ----
// Acceptance code and mask storage with registered read
`timescale 1ns/1ps
`default_nettype none
module cmc_accept_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_wr,
	input wire logic [AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_wr) begin
			mem[i_addr] <= i_wdata;
		end
		rdata_reg <= mem[i_addr];
	end

	assign o_rdata = rdata_reg;
endmodule : cmc_accept_mem
`default_nettype wire

// ---- logic/cmc_top.sv ----
// CAN mode, sleep, init and configuration control with register port
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cmc_top
	import cmc_pkg::*;
#(
	parameter int ACC_DEPTH = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_rx_pin,
	output logic o_tx_pin,
	input wire logic i_tx_bit,
	input wire logic i_bit_tick,
	input wire logic i_rx_active,
	input wire logic i_tx_empty,
	input wire logic i_busoff,
	input wire logic i_frame_valid,
	input wire logic [6:0] i_rx_flag_set,
	input wire logic [7:0] i_tx_flag_set,
	input wire logic i_abort_done,
	input wire logic i_cpu_stop,
	input wire logic i_cpu_wait,
	input wire logic i_special_mode,
	output logic o_rx_bit,
	output logic o_module_enable,
	output logic o_clock_select,
	output logic o_monitor_only,
	output logic o_busoff_recovery_mode,
	output logic o_counters_frozen,
	output logic o_abort_traffic,
	output logic o_synchronized,
	output logic [7:0] o_bus_timing_a,
	output logic [7:0] o_bus_timing_b,
	output logic [7:0] o_acceptance_control
);
	logic rst_meta_reg;
	logic rst_n;
	logic rx_sync;
	cmc_state_t state_reg;
	cmc_state_t state_next;
	logic [7:0] ctl_a_reg;
	logic [7:0] ctl_b_reg;
	logic enable_written_reg;
	logic wake_armed_reg;
	logic [7:0] rx_flags_reg;
	logic [7:0] rx_ien_reg;
	logic [7:0] tx_flags_reg;
	logic [7:0] tx_ien_reg;
	logic [7:0] abort_req_reg;
	logic [7:0] abort_ack_reg;
	logic [7:0] buf_sel_reg;
	logic [7:0] timing_a_reg;
	logic [7:0] timing_b_reg;
	logic [7:0] acc_ctl_reg;
	logic [7:0] rdata_reg;
	logic rd_mem_reg;
	logic [7:0] mem_rdata;
	logic [3:0] run_cnt_reg;
	logic [7:0] occ_cnt_reg;
	logic [$clog2(WAKE_CYCLES+1)-1:0] dom_cnt_reg;
	logic init_mode;
	logic out_of_init;
	logic sleep_ack;
	logic init_ack;
	logic bus_idle;
	logic wake_hit;
	logic resync_done;
	logic acc_hit;
	logic wr_a;
	logic force_recessive;

	// Reset release through two flops
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	cmc_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rx_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(rst_n),
		.i_async(i_rx_pin),
		.o_sync(rx_sync)
	);

	// Receiver sees own transmitter in loopback
	assign o_rx_bit = ctl_b_reg[B_LOOPBACK] ? i_tx_bit : rx_sync;

	// Acknowledges are decoded from the settled state
	assign sleep_ack = (state_reg == ST_SLEEP);
	assign init_ack = (state_reg == ST_INIT);
	assign init_mode = ctl_a_reg[A_INIT_RQ] && init_ack;
	assign out_of_init = !ctl_a_reg[A_INIT_RQ] && !init_ack;
	assign bus_idle = !i_rx_active && i_tx_empty;
	assign wr_a = i_wr && (i_addr == OFF_CTL_A);
	assign acc_hit = (i_addr >= OFF_ACC_BASE) &&
		(i_addr < OFF_ACC_BASE + 6'(ACC_DEPTH));

	// Wake on dominant level, optionally filtered by pulse length
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dom_cnt_reg <= '0;
		end else if (state_reg != ST_SLEEP || o_rx_bit) begin
			dom_cnt_reg <= '0;
		end else if (dom_cnt_reg != WAKE_CYCLES[$bits(dom_cnt_reg)-1:0]) begin
			dom_cnt_reg <= dom_cnt_reg + 1'b1;
		end
	end

	assign wake_hit = (state_reg == ST_SLEEP) && wake_armed_reg &&
		!o_rx_bit && (!ctl_b_reg[B_WAKE_FILT] ||
		dom_cnt_reg >= WAKE_CYCLES[$bits(dom_cnt_reg)-1:0] - 1'b1);

	// Wake capability is fixed at sleep entry
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_armed_reg <= 1'b0;
		end else if (state_reg != ST_SLEEP) begin
			wake_armed_reg <= ctl_a_reg[A_WAKE_EN];
		end
	end

	// Resynchronisation counter on bit ticks
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_cnt_reg <= '0;
			occ_cnt_reg <= '0;
		end else if (state_reg != ST_RESYNC) begin
			run_cnt_reg <= '0;
			occ_cnt_reg <= '0;
		end else if (i_bit_tick) begin
			if (!o_rx_bit) begin
				run_cnt_reg <= '0;
			end else if (run_cnt_reg == 4'(RECESSIVE_RUN - 1)) begin
				run_cnt_reg <= '0;
				occ_cnt_reg <= occ_cnt_reg + 1'b1;
			end else begin
				run_cnt_reg <= run_cnt_reg + 1'b1;
			end
		end
	end

	always_comb begin
		resync_done = 1'b0;
		if (i_bit_tick && o_rx_bit &&
			run_cnt_reg == 4'(RECESSIVE_RUN - 1)) begin
			if (!i_busoff) begin
				resync_done = 1'b1;
			end else if (occ_cnt_reg == 8'(BUSOFF_RUNS - 1)) begin
				resync_done = 1'b1;
			end
		end
	end

	// Mode state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (ctl_a_reg[A_INIT_RQ]) begin
					state_next = ST_INIT;
				end else if (ctl_a_reg[A_SLEEP_RQ] && bus_idle) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (ctl_a_reg[A_INIT_RQ]) begin
					state_next = ST_INIT;
				end else if (!ctl_a_reg[A_SLEEP_RQ]) begin
					state_next = ST_RESYNC;
				end else if (wake_hit) begin
					state_next = ST_RESYNC;
				end
			end
			ST_INIT: begin
				if (!ctl_a_reg[A_INIT_RQ]) begin
					state_next = ST_RESYNC;
				end
			end
			ST_RESYNC: begin
				if (ctl_a_reg[A_INIT_RQ]) begin
					state_next = ST_INIT;
				end else if (resync_done) begin
					state_next = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RESYNC;
		end else begin
			state_reg <= state_next;
		end
	end

	// control_reg_a request bits
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_a_reg[A_SLEEP_RQ] <= CTL_A_RST[A_SLEEP_RQ];
			ctl_a_reg[A_INIT_RQ] <= CTL_A_RST[A_INIT_RQ];
			ctl_a_reg[A_WAKE_EN] <= CTL_A_RST[A_WAKE_EN];
		end else begin
			if (wake_hit) begin
				ctl_a_reg[A_SLEEP_RQ] <= 1'b0;
			end else if (wr_a) begin
				if (i_wdata[A_SLEEP_RQ] && !rx_flags_reg[RX_WAKE_FLAG]) begin
					ctl_a_reg[A_SLEEP_RQ] <= 1'b1;
				end else if (!i_wdata[A_SLEEP_RQ] && sleep_ack) begin
					ctl_a_reg[A_SLEEP_RQ] <= 1'b0;
				end
			end
			if (wr_a) begin
				if (i_wdata[A_INIT_RQ]) begin
					ctl_a_reg[A_INIT_RQ] <= 1'b1;
				end else if (init_ack) begin
					ctl_a_reg[A_INIT_RQ] <= 1'b0;
				end
			end
			if (wr_a && out_of_init) begin
				ctl_a_reg[A_WAKE_EN] <= i_wdata[A_WAKE_EN];
			end
		end
	end

	// control_reg_a remaining bits, held reset in init
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_a_reg[A_FRAME] <= CTL_A_RST[A_FRAME];
			ctl_a_reg[A_RXACT] <= CTL_A_RST[A_RXACT];
			ctl_a_reg[A_STOPWAIT] <= CTL_A_RST[A_STOPWAIT];
			ctl_a_reg[A_SYNC] <= CTL_A_RST[A_SYNC];
			ctl_a_reg[A_TIMER] <= CTL_A_RST[A_TIMER];
		end else if (init_mode) begin
			ctl_a_reg[A_FRAME] <= CTL_A_RST[A_FRAME];
			ctl_a_reg[A_RXACT] <= CTL_A_RST[A_RXACT];
			ctl_a_reg[A_STOPWAIT] <= CTL_A_RST[A_STOPWAIT];
			ctl_a_reg[A_SYNC] <= CTL_A_RST[A_SYNC];
			ctl_a_reg[A_TIMER] <= CTL_A_RST[A_TIMER];
		end else begin
			ctl_a_reg[A_RXACT] <= i_rx_active;
			ctl_a_reg[A_SYNC] <= (state_next == ST_RUN);
			if (i_frame_valid && state_reg == ST_RUN &&
				!ctl_b_reg[B_LOOPBACK]) begin
				ctl_a_reg[A_FRAME] <= 1'b1;
			end else if (wr_a && i_wdata[A_FRAME]) begin
				ctl_a_reg[A_FRAME] <= 1'b0;
			end
			if (wr_a && out_of_init) begin
				ctl_a_reg[A_STOPWAIT] <= i_wdata[A_STOPWAIT];
				ctl_a_reg[A_TIMER] <= i_wdata[A_TIMER];
			end
		end
	end

	// control_reg_b, writable only in init mode
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_b_reg[7:2] <= CTL_B_RST[7:2];
			enable_written_reg <= 1'b0;
		end else if (i_wr && i_addr == OFF_CTL_B && init_mode) begin
			ctl_b_reg[7:2] <= {ctl_b_reg[B_ENABLE], i_wdata[6:2]};
			if (i_special_mode || !enable_written_reg) begin
				ctl_b_reg[B_ENABLE] <= i_wdata[B_ENABLE];
				enable_written_reg <= 1'b1;
			end
		end
	end

	assign ctl_b_reg[B_SLEEP_ACK] = sleep_ack;
	assign ctl_b_reg[B_INIT_ACK] = init_ack;

	// Timing and acceptance configuration
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timing_a_reg <= GEN_RST;
			timing_b_reg <= GEN_RST;
			acc_ctl_reg <= GEN_RST;
		end else if (i_wr && init_mode) begin
			if (i_addr == OFF_TIMING_A) begin
				timing_a_reg <= i_wdata;
			end
			if (i_addr == OFF_TIMING_B) begin
				timing_b_reg <= i_wdata;
			end
			if (i_addr == OFF_ACC_CTL) begin
				acc_ctl_reg <= i_wdata;
			end
		end
	end

	cmc_accept_mem #(.DEPTH(ACC_DEPTH), .AW(4)) u_accept_mem (
		.i_sys_clk(i_sys_clk),
		.i_wr(i_wr && acc_hit && init_mode),
		.i_addr(i_addr[3:0]),
		.i_wdata(i_wdata),
		.o_rdata(mem_rdata)
	);

	// Receiver and transmit flag groups; set wins over clear
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_flags_reg <= GEN_RST;
			tx_flags_reg <= TX_FLAGS_RST;
		end else if (init_mode) begin
			rx_flags_reg <= GEN_RST;
			tx_flags_reg <= TX_FLAGS_RST;
		end else begin
			rx_flags_reg <= (rx_flags_reg & ~((i_wr &&
				i_addr == OFF_RX_FLAGS) ? i_wdata : 8'h00)) |
				{wake_hit, i_rx_flag_set};
			tx_flags_reg <= (tx_flags_reg & ~((i_wr &&
				i_addr == OFF_TX_FLAGS) ? i_wdata : 8'h00)) | i_tx_flag_set;
		end
	end

	// Enables, abort and buffer select
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ien_reg <= GEN_RST;
			tx_ien_reg <= GEN_RST;
			abort_req_reg <= GEN_RST;
			abort_ack_reg <= GEN_RST;
			buf_sel_reg <= GEN_RST;
		end else if (init_mode) begin
			rx_ien_reg <= GEN_RST;
			tx_ien_reg <= GEN_RST;
			abort_req_reg <= GEN_RST;
			abort_ack_reg <= GEN_RST;
			buf_sel_reg <= GEN_RST;
		end else begin
			if (i_wr && i_addr == OFF_RX_IEN && out_of_init) begin
				rx_ien_reg <= i_wdata;
			end
			if (i_wr && i_addr == OFF_TX_IEN && out_of_init) begin
				tx_ien_reg <= i_wdata;
			end
			if (i_wr && i_addr == OFF_ABORT_REQ) begin
				abort_req_reg <= i_wdata;
			end
			if (i_abort_done) begin
				abort_ack_reg <= abort_req_reg;
			end
			if (i_wr && i_addr == OFF_BUF_SEL) begin
				buf_sel_reg <= i_wdata;
			end
		end
	end

	// Read path, data one cycle after the strobe
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
			rd_mem_reg <= 1'b0;
		end else begin
			rd_mem_reg <= i_rd && acc_hit;
			rdata_reg <= 8'h00;
			if (i_rd) begin
				unique case (i_addr)
					OFF_CTL_A: rdata_reg <= ctl_a_reg;
					OFF_CTL_B: rdata_reg <= ctl_b_reg;
					OFF_TIMING_A: rdata_reg <= timing_a_reg;
					OFF_TIMING_B: rdata_reg <= timing_b_reg;
					OFF_RX_FLAGS: rdata_reg <= rx_flags_reg;
					OFF_RX_IEN: rdata_reg <= rx_ien_reg;
					OFF_TX_FLAGS: rdata_reg <= tx_flags_reg;
					OFF_TX_IEN: rdata_reg <= tx_ien_reg;
					OFF_ABORT_REQ: rdata_reg <= abort_req_reg;
					OFF_ABORT_ACK: rdata_reg <= abort_ack_reg;
					OFF_BUF_SEL: rdata_reg <= buf_sel_reg;
					OFF_ACC_CTL: rdata_reg <= acc_ctl_reg;
					default: rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	assign o_rdata = rd_mem_reg ? mem_rdata : rdata_reg;

	// Transmit pin: recessive whenever sending is unsafe
	assign force_recessive = ctl_a_reg[A_INIT_RQ] ||
		i_cpu_stop || (i_cpu_wait && ctl_a_reg[A_STOPWAIT]) ||
		ctl_b_reg[B_MONITOR] || ctl_b_reg[B_LOOPBACK] ||
		!ctl_b_reg[B_ENABLE] || state_reg != ST_RUN;
	assign o_tx_pin = force_recessive ? 1'b1 : i_tx_bit;

	assign o_abort_traffic = ctl_a_reg[A_INIT_RQ];
	assign o_module_enable = ctl_b_reg[B_ENABLE];
	assign o_clock_select = ctl_b_reg[B_CLKSEL];
	assign o_monitor_only = ctl_b_reg[B_MONITOR];
	assign o_counters_frozen = ctl_b_reg[B_MONITOR];
	assign o_busoff_recovery_mode = ctl_b_reg[B_BUSOFF_RECOVERY_MODE];
	assign o_synchronized = ctl_a_reg[A_SYNC];
	assign o_bus_timing_a = timing_a_reg;
	assign o_bus_timing_b = timing_b_reg;
	assign o_acceptance_control = acc_ctl_reg;
endmodule : cmc_top
`default_nettype wire

// ---- verif/cmc_monitor.sv ----
// Port checker for the mode control block
`timescale 1ns/1ps
`default_nettype none
module cmc_monitor (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_cpu_stop,
	input wire logic i_bit_tick,
	input wire logic i_busoff,
	input wire logic o_rx_bit,
	input wire logic o_tx_pin,
	input wire logic o_abort_traffic,
	input wire logic o_synchronized,
	input wire logic o_monitor_only,
	input wire logic o_counters_frozen,
	input wire logic o_module_enable,
	input wire logic [7:0] o_bus_timing_a
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	logic [3:0] run_reg;
	// Consecutive recessive bit ticks, saturating
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_reg <= 4'h0;
		end else if (i_bit_tick && !o_rx_bit) begin
			run_reg <= 4'h0;
		end else if (i_bit_tick && run_reg != 4'hF) begin
			run_reg <= run_reg + 4'h1;
		end
	end
	property p_init_tx;
		o_abort_traffic |-> o_tx_pin;
	endproperty
	a_init_tx: assert property (p_init_tx)
		else $error("tx pin not recessive during init request");
	property p_stop_tx;
		i_cpu_stop |-> o_tx_pin;
	endproperty
	a_stop_tx: assert property (p_stop_tx)
		else $error("tx pin not recessive in stop");
	property p_listen;
		o_monitor_only |-> o_tx_pin && o_counters_frozen;
	endproperty
	a_listen: assert property (p_listen)
		else $error("listen only mode transmits or counts");
	property p_timing_lock;
		$changed(o_bus_timing_a) |-> $past(o_abort_traffic);
	endproperty
	a_timing_lock: assert property (p_timing_lock)
		else $error("timing register changed outside init");
	property p_enable_lock;
		$changed(o_module_enable) |-> $past(o_abort_traffic);
	endproperty
	a_enable_lock: assert property (p_enable_lock)
		else $error("module enable changed outside init");
	property p_sync_drop;
		o_abort_traffic |=> !o_synchronized;
	endproperty
	a_sync_drop: assert property (p_sync_drop)
		else $error("still synchronized in init");
	property p_resync;
		$rose(o_synchronized) && !i_busoff |-> run_reg >= 4'hB;
	endproperty
	a_resync: assert property (p_resync)
		else $error("synchronized before eleven recessive bits");
	property p_init_hold;
		$fell(o_abort_traffic) |-> $past(o_abort_traffic, 2);
	endproperty
	a_init_hold: assert property (p_init_hold)
		else $error("init request cleared before acknowledge");
endmodule : cmc_monitor
bind cmc_top cmc_monitor i_mon (.*);
`default_nettype wire

// ---- verif/cmc_can_node.sv ----
// Far-side CAN node model: wired bus and bit timing
`timescale 1ns/1ps
`default_nettype none
module cmc_can_node #(
	parameter int BIT_CYC = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_tx_pin,
	input wire logic i_dominant,
	output logic o_rx_pin,
	output logic o_bit_tick
);
	int cyc = 0;
	// Dominant low wins on the shared bus
	assign o_rx_pin = i_tx_pin & !i_dominant;
	assign o_bit_tick = (cyc == BIT_CYC - 1);
	always @(posedge i_sys_clk) begin
		cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
	end
endmodule : cmc_can_node
`default_nettype wire

// ---- verif/cmc_top_tb.sv ----
// Self-checking testbench for the mode control block
`timescale 1ns/1ps
`default_nettype none
module cmc_top_tb;
	import cmc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic tx_bit = 1'b1;
	logic rx_act = 1'b0;
	logic busoff = 1'b0;
	logic frame = 1'b0;
	logic stop = 1'b0;
	logic wait_m = 1'b0;
	logic dom = 1'b0;
	wire logic rx_pin, tick, tx_pin, rx_bit, men, csel, mon, busoff_recovery_mode, sync, abrt;
	wire logic [7:0] rdata, bta;
	int n_fail = 0;
	int cmp_count = 0;
	logic [7:0] d;
	cmc_top i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
		.i_rx_pin(rx_pin), .o_tx_pin(tx_pin), .i_tx_bit(tx_bit),
		.i_bit_tick(tick), .i_rx_active(rx_act), .i_tx_empty(1'b1),
		.i_busoff(busoff), .i_frame_valid(frame), .i_rx_flag_set(7'h00),
		.i_tx_flag_set(8'h00), .i_abort_done(1'b0), .i_cpu_stop(stop),
		.i_cpu_wait(wait_m), .i_special_mode(1'b0), .o_rx_bit(rx_bit),
		.o_module_enable(men), .o_clock_select(csel), .o_monitor_only(mon),
		.o_busoff_recovery_mode(busoff_recovery_mode), .o_counters_frozen(),
		.o_abort_traffic(abrt), .o_synchronized(sync),
		.o_bus_timing_a(bta), .o_bus_timing_b(), .o_acceptance_control());
	cmc_can_node i_node (.i_sys_clk(clk), .i_tx_pin(tx_pin),
		.i_dominant(dom), .o_rx_pin(rx_pin), .o_bit_tick(tick));
	initial forever #5 clk = ~clk;
	task report_and_stop;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
	endtask : wr
	// Two writes on back-to-back strobes to one address
	task wr2(input logic [5:0] a, input logic [7:0] v1, input logic [7:0] v2);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v1;
		@(posedge clk);
		wdata <= v2;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
	endtask : wr2
	task rd(input logic [5:0] a);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : rd
	// Waits bit ticks, then lets the result settle
	task ticks(input int n);
		repeat (n) @(posedge clk iff tick);
		step(2);
	endtask : ticks
	task wait_sync;
		for (int i = 0; i < 4000 && sync !== 1'b1; i++) step(1);
		chk("sync", sync, 1'b1);
	endtask : wait_sync
	task init_cycle;
		wr(OFF_CTL_A, 8'h01);
		step(2);
		wr(OFF_CTL_A, 8'h00);
	endtask : init_cycle
	task t_reset;
		rd(OFF_CTL_B);
		chk("ctl_b", d, CTL_B_RST);
		rd(OFF_TX_FLAGS);
		chk("tx_flags", d, TX_FLAGS_RST);
		rd(6'h3F);
		chk("unmapped", d, 8'h00);
		wait_sync();
		wr(OFF_TX_IEN, 8'hFF);
		rd(OFF_TX_IEN);
		chk("tx_ien", d, 8'hFF);
		wr(OFF_TIMING_A, 8'h5A);
		chk("timing_a", bta, 8'h00);
	endtask : t_reset
	task t_init;
		wr2(OFF_CTL_A, 8'h01, 8'h00);
		chk("abort", abrt, 1'b1);
		chk("tx_pin", tx_pin, 1'b1);
		rd(OFF_CTL_B);
		chk("init_ack", d[B_INIT_ACK], 1'b1);
		rd(OFF_TX_IEN);
		chk("tx_ien", d, 8'h00);
		frame <= 1'b1;
		step(1);
		frame <= 1'b0;
		rd(OFF_CTL_A);
		chk("ctl_a", d, 8'h01);
		wr(OFF_TIMING_A, 8'h5A);
		chk("timing_a", bta, 8'h5A);
		wr(OFF_ACC_BASE, 8'hA5);
		rd(OFF_ACC_BASE);
		chk("acc_code", d, 8'hA5);
		wr(OFF_CTL_B, 8'hFF);
		rd(OFF_CTL_B);
		chk("ctl_b", d, 8'hFD);
		chk("enable", men, 1'b1);
		chk("clksel", csel, 1'b1);
		chk("monitor", mon, 1'b1);
		chk("busoff_recovery_mode", busoff_recovery_mode, 1'b1);
		tx_bit <= 1'b0;
		step(1);
		chk("rx_bit", rx_bit, 1'b0);
		tx_bit <= 1'b1;
		wr(OFF_CTL_B, 8'h00);
		rd(OFF_CTL_B);
		chk("ctl_b", d, 8'h81);
		wr(OFF_CTL_A, 8'h00);
		wait_sync();
	endtask : t_init
	task t_txpin;
		tx_bit <= 1'b0;
		step(1);
		chk("tx_pin", tx_pin, 1'b0);
		stop <= 1'b1;
		step(1);
		chk("tx_pin", tx_pin, 1'b1);
		stop <= 1'b0;
		wait_m <= 1'b1;
		step(1);
		chk("tx_pin", tx_pin, 1'b0);
		wr(OFF_CTL_A, 8'h20);
		chk("tx_pin", tx_pin, 1'b1);
		wr(OFF_CTL_A, 8'h00);
		wait_m <= 1'b0;
		tx_bit <= 1'b1;
	endtask : t_txpin
	task t_sleep;
		rx_act <= 1'b1;
		wr(OFF_CTL_A, 8'h02);
		step(4);
		rd(OFF_CTL_B);
		chk("sleep_ack", d[B_SLEEP_ACK], 1'b0);
		wr(OFF_CTL_A, 8'h00);
		rd(OFF_CTL_A);
		chk("sleep_rq", d[A_SLEEP_RQ], 1'b1);
		rx_act <= 1'b0;
		step(3);
		rd(OFF_CTL_B);
		chk("sleep_ack", d[B_SLEEP_ACK], 1'b1);
		dom <= 1'b1;
		step(250);
		rd(OFF_CTL_B);
		chk("sleep_ack", d[B_SLEEP_ACK], 1'b1);
		dom <= 1'b0;
		wr(OFF_CTL_A, 8'h00);
		rd(OFF_CTL_B);
		chk("sleep_ack", d[B_SLEEP_ACK], 1'b0);
		wait_sync();
	endtask : t_sleep
	task t_wake;
		wr(OFF_RX_IEN, 8'h80);
		wr(OFF_CTL_A, 8'h04);
		wr(OFF_CTL_A, 8'h06);
		step(3);
		rd(OFF_CTL_B);
		chk("sleep_ack", d[B_SLEEP_ACK], 1'b1);
		dom <= 1'b1;
		step(6);
		rd(OFF_CTL_A);
		chk("sleep_rq", d[A_SLEEP_RQ], 1'b0);
		rd(OFF_CTL_B);
		chk("sleep_ack", d[B_SLEEP_ACK], 1'b0);
		rd(OFF_RX_FLAGS);
		chk("wake_flag", d[RX_WAKE_FLAG], 1'b1);
		wr(OFF_CTL_A, 8'h06);
		rd(OFF_CTL_A);
		chk("sleep_rq", d[A_SLEEP_RQ], 1'b0);
		dom <= 1'b0;
		wr(OFF_RX_FLAGS, 8'h80);
	endtask : t_wake
	task t_resync(input logic bo, input int lo, input int hi);
		busoff <= bo;
		dom <= 1'b1;
		init_cycle();
		ticks(20);
		chk("sync", sync, 1'b0);
		dom <= 1'b0;
		ticks(lo);
		chk("sync", sync, 1'b0);
		ticks(hi);
		chk("sync", sync, 1'b1);
		busoff <= 1'b0;
	endtask : t_resync
	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		step(20);
		rst_n <= 1'b1;
		step(3);
		t_reset();
		t_init();
		t_txpin();
		t_sleep();
		t_wake();
		t_resync(1'b0, 10, 3);
		t_resync(1'b1, 1400, 20);
		report_and_stop();
	end
endmodule : cmc_top_tb
`default_nettype wire
